// *** design/ufs_top.sv ***
// Top: two engines, 12 MHz time base and register port
//
// Behaviour
// - Bus reset sets bus-reset flag
// - Ack, stall, timeout, errors set endpoint flag
// - Nak sets endpoint flag when enabled
// - Full speed captures sof frame number
// - Timeout leaves frame number unchanged
// - Timeout flag marks timeout event
// - Timeout counter increments, saturates at seven
// - Sof or eop clears timeout counter
// - Counter increments only when timeout enabled
// - Expired down counter raises timeout
// - Down counter steps at 12 MHz
// - Count resets to 0x2ee0
// - Count reads live down counter
// - Two engines at distinct addresses
// - Writing one clears a status flag
`timescale 1ns/10ps
`default_nettype none
module ufs_top (
    input wire logic clk_i, // 20 MHz clock
    input wire logic srst_i, // Sync reset, high
    input wire logic [15:0] reg_addr_i, // Register byte address
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [15:0] reg_wdata_i, // Write data
    output logic [15:0] reg_rdata_o, // Read data, next cycle
    input wire logic [1:0] usb_reset_i, // Bus reset per engine
    input wire logic [15:0] ep_done_i, // Done events, engine 2 in high byte
    input wire logic [15:0] ep_nak_i, // Nak events
    input wire logic [15:0] ep_nak_en_i, // Nak enables
    input wire logic [1:0] full_speed_i, // Full speed per engine
    input wire logic [1:0] sof_i, // Sof received
    input wire logic [21:0] sof_frame_i, // Frame numbers, engine 2 high
    input wire logic [1:0] eop_i, // Eop received
    input wire logic [1:0] timeout_en_i, // Timeout interrupt enables
    output logic [1:0] timeout_o // Timeout pulse per engine
);
    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    typedef struct packed {
        logic [24:0] acc;
        logic tick;
        logic [15:0] rdata;
        logic [1:0] to;
    } ufs_top_t;

    ufs_top_t st_reg, st_next;
    logic [15:0] flags [2];
    logic [15:0] frame [2];
    logic [13:0] count [2];
    logic [1:0] flags_clr;
    logic [1:0] count_wr;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Engines
    // ------------------------------------------------------------
    assign flags_clr[0] = reg_wr_i & hit(reg_addr_i, ufs_pkg::DEV1_EVENT_FLAGS_OFS);
    assign flags_clr[1] = reg_wr_i & hit(reg_addr_i, ufs_pkg::DEV2_EVENT_FLAGS_OFS);
    assign count_wr[0] = reg_wr_i & hit(reg_addr_i, ufs_pkg::DEV1_FRAME_INTERVAL_COUNT_OFS);
    assign count_wr[1] = reg_wr_i & hit(reg_addr_i, ufs_pkg::DEV2_FRAME_INTERVAL_COUNT_OFS);

    for (genvar g = 0; g < 2; g++) begin : g_eng
        ufs_engine ufs_engine_inst (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .usb_reset_i(usb_reset_i[g]),
            .ep_done_i(ep_done_i[8*g +: 8]),
            .ep_nak_i(ep_nak_i[8*g +: 8]),
            .ep_nak_en_i(ep_nak_en_i[8*g +: 8]),
            .full_speed_i(full_speed_i[g]),
            .sof_i(sof_i[g]),
            .sof_frame_i(sof_frame_i[11*g +: 11]),
            .eop_i(eop_i[g]),
            .timeout_en_i(timeout_en_i[g]),
            .tick_i(st_reg.tick),
            .flags_clr_i(flags_clr[g]),
            .flags_wdata_i(reg_wdata_i),
            .count_wr_i(count_wr[g]),
            .count_wdata_i(reg_wdata_i[13:0] & ufs_pkg::COUNT_WMASK[13:0]),
            .flags_o(flags[g]),
            .frame_o(frame[g]),
            .count_o(count[g])
        );
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Fractional accumulator, 12 ticks per 20 clocks
        if (st_reg.acc + 25'(ufs_pkg::TICK_HZ) >= 25'(ufs_pkg::CLK_HZ)) begin
            st_next.acc = st_reg.acc + 25'(ufs_pkg::TICK_HZ) - 25'(ufs_pkg::CLK_HZ);
            st_next.tick = 1'b1;
        end else begin
            st_next.acc = st_reg.acc + 25'(ufs_pkg::TICK_HZ);
            st_next.tick = 1'b0;
        end
        st_next.to = {frame[1][ufs_pkg::TIMEOUT_FLAG_BIT], frame[0][ufs_pkg::TIMEOUT_FLAG_BIT]};
        if (reg_rd_i) begin
            case (reg_addr_i)
                ufs_pkg::DEV1_EVENT_FLAGS_OFS: st_next.rdata = flags[0];
                ufs_pkg::DEV1_FRAME_NUMBER_OFS: st_next.rdata = frame[0];
                ufs_pkg::DEV1_FRAME_INTERVAL_COUNT_OFS: st_next.rdata = {2'h0, count[0]};
                ufs_pkg::DEV2_EVENT_FLAGS_OFS: st_next.rdata = flags[1];
                ufs_pkg::DEV2_FRAME_NUMBER_OFS: st_next.rdata = frame[1];
                ufs_pkg::DEV2_FRAME_INTERVAL_COUNT_OFS: st_next.rdata = {2'h0, count[1]};
                default: st_next.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '{acc: 25'h0, tick: 1'b0, rdata: 16'h0000, to: 2'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign timeout_o = st_reg.to;
endmodule
`default_nettype wire

// *** shared/ufs_pkg.sv ***
// Package: register map, field layout and timing constants for the frame status block
package ufs_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_HZ = 12000000;
    localparam logic [15:0] DEV1_EVENT_FLAGS_OFS = 16'hc090;
    localparam logic [15:0] DEV1_FRAME_NUMBER_OFS = 16'hc092;
    localparam logic [15:0] DEV1_FRAME_INTERVAL_COUNT_OFS = 16'hc094;
    localparam logic [15:0] DEV2_EVENT_FLAGS_OFS = 16'hc0b0;
    localparam logic [15:0] DEV2_FRAME_NUMBER_OFS = 16'hc0b2;
    localparam logic [15:0] DEV2_FRAME_INTERVAL_COUNT_OFS = 16'hc0b4;
    localparam int unsigned BUS_RESET_BIT = 8;
    localparam int unsigned TIMEOUT_FLAG_BIT = 15;
    localparam int unsigned TO_CNT_LSB = 12;
    localparam int unsigned TO_CNT_W = 3;
    localparam int unsigned FRAME_W = 11;
    localparam int unsigned COUNT_W = 14;
    localparam int unsigned EP_NUM = 8;
    localparam logic [2:0] TO_CNT_MAX = 3'h7;
    localparam logic [13:0] COUNT_RESET = 14'h2ee0;
    localparam logic [15:0] FLAGS_WMASK = 16'h01ff;
    localparam logic [15:0] COUNT_WMASK = 16'h3fff;
endpackage

// *** design/ufs_engine.sv ***
// One engine: event flags, frame capture and frame-interval timeout
`timescale 1ns/10ps
`default_nettype none
module ufs_engine (
    input wire logic clk_i, // Clock
    input wire logic srst_i, // Sync reset
    input wire logic usb_reset_i, // Bus reset seen
    input wire logic [7:0] ep_done_i, // Ack/stall/timeout/error per endpoint
    input wire logic [7:0] ep_nak_i, // Nak sent per endpoint
    input wire logic [7:0] ep_nak_en_i, // Nak counts as done
    input wire logic full_speed_i, // Full-speed link
    input wire logic sof_i, // Sof received, frame valid
    input wire logic [10:0] sof_frame_i, // Frame number of sof
    input wire logic eop_i, // Eop marker received
    input wire logic timeout_en_i, // Timeout interrupt enable
    input wire logic tick_i, // 12 MHz tick
    input wire logic flags_clr_i, // Flag write strobe
    input wire logic [15:0] flags_wdata_i, // Flag write data
    input wire logic count_wr_i, // Count write strobe
    input wire logic [13:0] count_wdata_i, // Count write data
    output logic [15:0] flags_o, // Event flags
    output logic [15:0] frame_o, // Frame number register
    output logic [13:0] count_o // Live down counter
);
    typedef struct packed {
        logic rst_flag;
        logic [7:0] ep_flag;
        logic to_flag;
        logic [2:0] to_cnt;
        logic [10:0] frame;
        logic [13:0] interval;
        logic [13:0] down;
    } ufs_eng_t;

    ufs_eng_t st_reg, st_next;
    logic marker;
    logic [15:0] clr;

    always_comb begin
        st_next = st_reg;
        marker = sof_i | eop_i;
        clr = flags_clr_i ? (flags_wdata_i & ufs_pkg::FLAGS_WMASK) : 16'h0000;
        // Set wins over clear
        st_next.rst_flag = (st_reg.rst_flag & ~clr[ufs_pkg::BUS_RESET_BIT]) | usb_reset_i;
        st_next.ep_flag = (st_reg.ep_flag & ~clr[7:0]) | ep_done_i | (ep_nak_i & ep_nak_en_i);
        if (sof_i && full_speed_i) begin
            st_next.frame = sof_frame_i;
        end
        if (count_wr_i) begin
            st_next.interval = count_wdata_i;
        end
        st_next.to_flag = 1'b0;
        if (marker) begin
            st_next.down = count_wr_i ? count_wdata_i : st_reg.interval;
            st_next.to_cnt = 3'h0;
        end else if (count_wr_i) begin
            st_next.down = count_wdata_i;
        end else if (tick_i) begin
            if (st_reg.down == 14'h0000) begin
                st_next.to_flag = 1'b1;
                st_next.down = st_reg.interval;
                if (timeout_en_i && st_reg.to_cnt != ufs_pkg::TO_CNT_MAX) begin
                    st_next.to_cnt = st_reg.to_cnt + 3'h1;
                end
            end else begin
                st_next.down = st_reg.down - 14'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '{rst_flag: 1'b0, ep_flag: 8'h00, to_flag: 1'b0, to_cnt: 3'h0, frame: 11'h000,
                        interval: ufs_pkg::COUNT_RESET, down: ufs_pkg::COUNT_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags_o = {7'h00, st_reg.rst_flag, st_reg.ep_flag};
    assign frame_o = {st_reg.to_flag, st_reg.to_cnt, 1'b0, st_reg.frame};
    assign count_o = st_reg.down;
endmodule
`default_nettype wire

// *** tb/ufs_checker.sv ***
// Checker: register port properties
`timescale 1ns/10ps
`default_nettype none
module ufs_checker (
    input wire logic clk_i, // Clk
    input wire logic srst_i, // Rst
    input wire logic [15:0] reg_addr_i, // Addr
    input wire logic reg_wr_i, // Wr
    input wire logic reg_rd_i, // Rd
    input wire logic [15:0] reg_wdata_i, // Wdata
    input wire logic [15:0] reg_rdata_o, // Rdata
    input wire logic [1:0] usb_reset_i, // Bus reset
    input wire logic [15:0] ep_done_i, // Done
    input wire logic [1:0] full_speed_i, // Speed
    input wire logic [1:0] sof_i, // Sof
    input wire logic [21:0] sof_frame_i // Frame
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire rd_fl = reg_rd_i && reg_addr_i == 16'hc090;
    wire rd_fr = reg_rd_i && reg_addr_i == 16'hc092;
    wire rd_ct = reg_rd_i && reg_addr_i == 16'hc094;
    wire mapped = reg_addr_i inside {16'hc090, 16'hc092, 16'hc094, 16'hc0b0, 16'hc0b2, 16'hc0b4};
    a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    a_flags_rsvd: assert property (rd_fl |=> reg_rdata_o[15:9] == 7'h00) else $error("flag bits high");
    a_count_rsvd: assert property (rd_ct |=> reg_rdata_o[15:14] == 2'h0)
        else $error("count bits high");
    a_frame_rsvd: assert property (rd_fr |=> !reg_rdata_o[11]) else $error("frame bit 11 high");
    a_w1c_clear: assert property (reg_wr_i && reg_addr_i == 16'hc090 && reg_wdata_i[8] && !usb_reset_i[0]
        ##1 !usb_reset_i[0] ##1 rd_fl |=> !reg_rdata_o[8]) else $error("flag not cleared");
    a_reset_flag: assert property (usb_reset_i[0] ##1 !(reg_wr_i && reg_addr_i == 16'hc090) ##1 rd_fl
        |=> reg_rdata_o[8]) else $error("bus reset flag missing");
    a_ep_done_set: assert property (rd_fl |=>
        (reg_rdata_o[7:0] & $past(ep_done_i[7:0], 2)) == $past(ep_done_i[7:0], 2)) else $error("done flag missing");
    a_sof_capture: assert property (rd_fr && $past(sof_i[0]) && $past(full_speed_i[0])
        |=> reg_rdata_o[10:0] == $past(sof_frame_i[10:0], 2)) else $error("frame not captured");
    a_ep_done_held: assert property (rd_fl && !$past(reg_wr_i) |=>
        (reg_rdata_o[7:0] & $past(ep_done_i[7:0], 3)) == $past(ep_done_i[7:0], 3)) else $error("done flag lost");
    a_sof_frame_held: assert property (rd_fr && $past(sof_i[0], 2) && $past(full_speed_i[0], 2)
        && !$past(sof_i[0]) |=> reg_rdata_o[10:0] == $past(sof_frame_i[10:0], 3)) else $error("frame not held");
endmodule
bind ufs_top ufs_checker ufs_checker_inst (.clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .usb_reset_i, .ep_done_i, .full_speed_i, .sof_i, .sof_frame_i);
`default_nettype wire

// *** tb/ufs_host_model.sv ***
// Host model: bus events and sof/eop markers
`timescale 1ns/10ps
`default_nettype none
module ufs_host_model (
    input wire logic clk_i, // Clk
    output logic [1:0] usb_reset_o, // Bus reset
    output logic [15:0] ep_done_o, // Done
    output logic [15:0] ep_nak_o, // Nak
    output logic [1:0] sof_o, // Sof
    output logic [21:0] sof_frame_o, // Frame
    output logic [1:0] eop_o // Eop
);
    initial begin
        {usb_reset_o, ep_done_o, ep_nak_o, sof_o, eop_o} = '0;
        sof_frame_o = 22'h3fffff;
    end
    // One-cycle pulse; frame bus flips once released
    task send(input logic [1:0] r, input logic [15:0] d, input logic [15:0] n, input logic [1:0] s,
        input logic [1:0] e, input logic [21:0] f);
        @(posedge clk_i);
        {usb_reset_o, ep_done_o, ep_nak_o, sof_o, eop_o} <= {r, d, n, s, e};
        sof_frame_o <= f;
        @(posedge clk_i);
        {usb_reset_o, ep_done_o, ep_nak_o, sof_o, eop_o} <= '0;
        sof_frame_o <= ~f;
    endtask
endmodule
`default_nettype wire

// *** tb/test_ufs_top.sv ***
// Testbench: register and bus event scenarios
`timescale 1ns/10ps
`default_nettype none
module test_ufs_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [15:0] reg_addr_i = '0, reg_wdata_i = '0, ep_nak_en_i = '0, ep_done_i, ep_nak_i, reg_rdata_o, v;
    logic [1:0] usb_reset_i, sof_i, eop_i, timeout_o, full_speed_i = '0, timeout_en_i = '0;
    logic [21:0] sof_frame_i;
    int miscompares = 0, total_checks = 0, n, eng = 0;
    always #25 clk_i = ~clk_i;
    ufs_top ufs_top_inst (.clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
        .usb_reset_i, .ep_done_i, .ep_nak_i, .ep_nak_en_i, .full_speed_i, .sof_i, .sof_frame_i, .eop_i,
        .timeout_en_i, .timeout_o);
    ufs_host_model ufs_host_model_inst (.clk_i, .usb_reset_o(usb_reset_i), .ep_done_o(ep_done_i),
        .ep_nak_o(ep_nak_i), .sof_o(sof_i), .sof_frame_o(sof_frame_i), .eop_o(eop_i));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask
    task wait_to(input int k);
        n = 0;
        while (k > 0 && n < 2000) begin
            @(posedge clk_i);
            #1;
            n++;
            if (timeout_o[eng] === 1'b1) k--;
        end
        chk("timeout", 16'(k), 16'h0000);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(16'hc094);
        chk("count", 16'(v inside {[16'h2ed8:16'h2ee0]}), 16'h0001);
        rd(16'hc092);
        chk("frame", v, 16'h0000);
        rd(16'hc096);
        chk("unmapped", v, 16'h0000);
        $display("test reset done");
        ufs_host_model_inst.send(2'b01, '0, '0, '0, '0, '0);
        rd(16'hc090);
        chk("flags", v, 16'h0100);
        wr(16'hc090, 16'h0000);
        rd(16'hc090);
        chk("flags", v, 16'h0100);
        wr(16'hc090, 16'h0100);
        rd(16'hc090);
        chk("flags", v, 16'h0000);
        @(posedge clk_i) ep_nak_en_i <= 16'h0002;
        ufs_host_model_inst.send('0, 16'h4081, 16'h0006, '0, '0, '0);
        rd(16'hc090);
        chk("flags", v, 16'h0083);
        rd(16'hc0b0);
        chk("flags2", v, 16'h0040);
        $display("test flags done");
        @(posedge clk_i) full_speed_i <= 2'b01;
        ufs_host_model_inst.send('0, '0, '0, 2'b11, '0, {11'h123, 11'h5a5});
        rd(16'hc092);
        chk("frame", v, 16'h05a5);
        rd(16'hc0b2);
        chk("frame2", v, 16'h0000);
        @(posedge clk_i) full_speed_i <= 2'b11;
        ufs_host_model_inst.send('0, '0, '0, 2'b10, '0, {11'h7ff, 11'h000});
        rd(16'hc0b2);
        chk("frame2", v, 16'h07ff);
        $display("test frame done");
        @(posedge clk_i) timeout_en_i <= 2'b01;
        wr(16'hc094, 16'h0005);
        rd(16'hc094);
        chk("count", 16'(v <= 16'h0005), 16'h0001);
        wait_to(1);
        wait_to(6);
        chk("period", 16'(n inside {[59:61]}), 16'h0001);
        wait_to(2);
        rd(16'hc092);
        chk("frame", v, 16'h75a5);
        ufs_host_model_inst.send('0, '0, '0, '0, 2'b01, '0);
        wait_to(1);
        chk("reload", 16'(n inside {[8:12]}), 16'h0001);
        rd(16'hc092);
        chk("frame", v, 16'h15a5);
        @(posedge clk_i) timeout_en_i <= 2'b00;
        wait_to(2);
        rd(16'hc092);
        chk("frame", v, 16'h15a5);
        $display("test timeout done");
        eng = 1;
        wr(16'hc0b4, 16'h0005);
        rd(16'hc0b4);
        chk("count2", 16'(v <= 16'h0005), 16'h0001);
        rd(16'hc094);
        chk("count", 16'(v <= 16'h0005), 16'h0001);
        wait_to(1);
        rd(16'hc0b2);
        chk("frame2", v, 16'h07ff);
        $display("test second engine done");
        close_out();
    end
endmodule
`default_nettype wire
